// >>> src/ctad_pkg.sv
// Purpose: constants and types of the transfer and arithmetic datapath
// Assumes: one clock, asynchronous active-low reset
// Notes: flags word is {h, n, z, v, c}
// What this block does
// - transfer copies register to register, memory to register, register to memory or an immediate to a register, in byte, word or long size.
// - the peripheral byte read and write operations are refused on this device.
// - a word or long stack restore is a load from the stack pointer address with post-increment.
// - a word or long stack save is a store of the register to the stack pointer address with pre-decrement.
// - plus and minus combine the destination with a register or immediate in any size and write the destination.
// - minus refuses a byte immediate source.
// - plus with carry and minus with borrow take byte operands only and fold in the carry flag.
// - count up and count down step a register by 1 or 2 in byte, word or long size.
// - a byte count steps by 1 only.
// - the long constant add and subtract step a 32-bit register by 1, 2 or 4 in long size only.
// - the decimal adjusts turn a byte sum or difference into packed bcd digits using the held flags.
// - unsigned multiply gives 16 bits from 8 or 32 bits from 16 in the destination.
// - signed multiply does the same on two's-complement values.
// - the register file is seen as sixteen bytes, sixteen words or eight longs over one storage.
package ctad_pkg;
   localparam int unsigned NREG = 8;
   localparam logic [2:0] SP_IDX = 3'h7;
   localparam int FLAG_C = 0;
   localparam int FLAG_V = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 3;
   localparam int FLAG_H = 4;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam int HB_B = 4;
   localparam int HB_W = 12;
   localparam int HB_L = 28;
   localparam logic [31:0] MASK_B = 32'h0000_00ff;
   localparam logic [31:0] MASK_W = 32'h0000_ffff;
   localparam logic [31:0] MASK_L = 32'hffff_ffff;
   localparam logic [31:0] BYTES_B = 32'h0000_0001;
   localparam logic [31:0] BYTES_W = 32'h0000_0002;
   localparam logic [31:0] BYTES_L = 32'h0000_0004;
   localparam logic [3:0] LANE_BL = 4'h1;
   localparam logic [3:0] LANE_BH = 4'h2;
   localparam logic [3:0] LANE_WR = 4'h3;
   localparam logic [3:0] LANE_WE = 4'hc;
   localparam logic [3:0] LANE_L = 4'hf;
   localparam logic [2:0] STEP_1 = 3'h1;
   localparam logic [2:0] STEP_2 = 3'h2;
   localparam logic [2:0] STEP_4 = 3'h4;
   localparam logic [7:0] BCD_LO_FIX = 8'h06;
   localparam logic [7:0] BCD_HI_FIX = 8'h60;
   localparam logic [7:0] BCD_MAX = 8'h99;
   localparam logic [3:0] NIB_MAX = 4'h9;

   typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} ctad_size_t;
   typedef enum logic [1:0] {AM_IND, AM_POSTINC, AM_PREDEC} ctad_am_t;
   typedef enum logic [4:0] {
      OP_XFER_REG, OP_XFER_IMM, OP_LOAD, OP_STORE, OP_STACK_RESTORE, OP_STACK_SAVE,
      OP_PLUS, OP_MINUS, OP_PLUS_C, OP_MINUS_B, OP_COUNT_UP, OP_COUNT_DOWN,
      OP_PLUS_K, OP_MINUS_K, OP_ADJ_ADD, OP_ADJ_SUB, OP_MUL_U, OP_MUL_S,
      OP_PERI_RD, OP_PERI_WR
   } ctad_op_t;
endpackage : ctad_pkg

// >>> src/ctad_regfile.sv
// Purpose: eight long registers with byte-lane writes and two registered reads
// Assumes: reads and writes are never aimed at the same register in one cycle
// Notes: byte lanes give the byte, word and long views one storage
`timescale 1ns/1ps
module ctad_regfile (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // read ports
   input wire logic [2:0] rd_a_idx_i,
   input wire logic [2:0] rd_b_idx_i,
   output logic [31:0] rd_a_data_o,
   output logic [31:0] rd_b_data_o,
   // write port
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [3:0] wr_lane_i,
   input wire logic [31:0] wr_data_i
);
   import ctad_pkg::*;

   logic [31:0] mem_q [NREG];
   logic [31:0] mem_d [NREG];
   logic [31:0] rda_q;
   logic [31:0] rdb_q;

   ////////////////////////////////////////////////////////////////////////
   // lane merge, so a byte write leaves the other three bytes alone
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         mem_d[i] = mem_q[i];
      end
      for (int j = 0; j < 4; j++) begin
         if (wr_en_i && wr_lane_i[j]) begin
            mem_d[wr_idx_i][8*j +: 8] = wr_data_i[8*j +: 8];
         end
      end
   end

   // storage and registered read data
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < NREG; i++) begin
            mem_q[i] <= 32'h0000_0000;
         end
         rda_q <= 32'h0000_0000;
         rdb_q <= 32'h0000_0000;
      end else begin
         mem_q <= mem_d;
         rda_q <= mem_q[rd_a_idx_i];
         rdb_q <= mem_q[rd_b_idx_i];
      end
   end

   assign rd_a_data_o = rda_q;
   assign rd_b_data_o = rdb_q;
endmodule : ctad_regfile

// >>> src/ctad_datapath.sv
// Purpose: transfer, stack, add, subtract, step, decimal adjust and multiply
// Assumes: memory answers each request with a one-cycle ack
// Notes: one operation in flight; op_ready_o is low until it retires
`timescale 1ns/1ps
module ctad_datapath (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // operation request
   input wire logic op_valid_i,
   output logic op_ready_o,
   input wire ctad_pkg::ctad_op_t op_code_i,
   input wire ctad_pkg::ctad_size_t op_size_i,
   input wire logic [3:0] dst_sel_i,
   input wire logic [3:0] src_sel_i,
   input wire logic [2:0] addr_sel_i,
   input wire ctad_pkg::ctad_am_t addr_mode_i,
   input wire logic use_imm_i,
   input wire logic [31:0] imm_i,
   input wire logic [2:0] step_i,
   // completion
   output logic done_o,
   output logic illegal_o,
   output logic [31:0] result_o,
   output logic [4:0] flags_o,
   // memory access
   output logic mem_req_o,
   output logic mem_we_o,
   output ctad_pkg::ctad_size_t mem_size_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_rdata_i
);
   import ctad_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_READ, S_EXEC, S_MEM} ctad_state_t;

   ////////////////////////////////////////////////////////////////////////
   // view helpers over a long register
   function automatic logic [31:0] szmask(ctad_size_t s);
      unique case (s)
         SZ_B: szmask = MASK_B;
         SZ_W: szmask = MASK_W;
         default: szmask = MASK_L;
      endcase
   endfunction : szmask

   function automatic logic [31:0] extract(logic [31:0] v, ctad_size_t s, logic [3:0] sel);
      unique case (s)
         SZ_B: extract = sel[3] ? {24'h0, v[7:0]} : {24'h0, v[15:8]};
         SZ_W: extract = sel[3] ? {16'h0, v[31:16]} : {16'h0, v[15:0]};
         default: extract = v;
      endcase
   endfunction : extract

   function automatic logic [3:0] lanes(ctad_size_t s, logic [3:0] sel);
      unique case (s)
         SZ_B: lanes = sel[3] ? LANE_BL : LANE_BH;
         SZ_W: lanes = sel[3] ? LANE_WE : LANE_WR;
         default: lanes = LANE_L;
      endcase
   endfunction : lanes

   function automatic logic [31:0] spread(logic [31:0] v, ctad_size_t s);
      unique case (s)
         SZ_B: spread = {4{v[7:0]}};
         SZ_W: spread = {2{v[15:0]}};
         default: spread = v;
      endcase
   endfunction : spread

   function automatic logic msb(logic [31:0] v, ctad_size_t s);
      unique case (s)
         SZ_B: msb = v[7];
         SZ_W: msb = v[15];
         default: msb = v[31];
      endcase
   endfunction : msb

   function automatic logic is_mem(ctad_op_t op);
      is_mem = op inside {OP_LOAD, OP_STORE, OP_STACK_RESTORE, OP_STACK_SAVE};
   endfunction : is_mem

   ////////////////////////////////////////////////////////////////////////
   ctad_state_t state_q, state_d;
   ctad_op_t op_q, op_d;
   ctad_size_t size_q, size_d;
   ctad_am_t am_q, am_d;
   logic [3:0] dsel_q, dsel_d, ssel_q, ssel_d;
   logic [2:0] asel_q, asel_d, step_q, step_d;
   logic immf_q, immf_d;
   logic [31:0] imm_q, imm_d;
   logic [4:0] flags_q, flags_d;
   logic [31:0] result_q, result_d, maddr_q, maddr_d, mwdata_q, mwdata_d;
   logic done_q, done_d, ill_q, ill_d, mreq_q, mreq_d, mwe_q, mwe_d, zchk_q, zchk_d;
   ctad_size_t msize_q, msize_d;
   logic [31:0] rfa, rfb, wr_data;
   logic [2:0] wr_idx;
   logic [3:0] wr_lane;
   logic wr_en;
   logic acc;

   assign op_ready_o = (state_q == S_IDLE);
   assign acc = op_valid_i && op_ready_o;

   ctad_regfile u_regs (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .rd_a_idx_i(is_mem(op_q) ? asel_q : dsel_q[2:0]),
      .rd_b_idx_i(ssel_q[2:0]),
      .rd_a_data_o(rfa),
      .rd_b_data_o(rfb),
      .wr_en_i(wr_en),
      .wr_idx_i(wr_idx),
      .wr_lane_i(wr_lane),
      .wr_data_i(wr_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // operation capture; stack forms are pinned to the stack pointer
   always_comb begin
      op_d = op_q;
      size_d = size_q;
      am_d = am_q;
      dsel_d = dsel_q;
      ssel_d = ssel_q;
      asel_d = asel_q;
      step_d = step_q;
      immf_d = immf_q;
      imm_d = imm_q;
      if (acc) begin
         op_d = op_code_i;
         size_d = op_size_i;
         dsel_d = dst_sel_i;
         ssel_d = src_sel_i;
         step_d = step_i;
         imm_d = imm_i;
         immf_d = use_imm_i || (op_code_i == OP_XFER_IMM);
         asel_d = addr_sel_i;
         am_d = addr_mode_i;
         if (op_code_i == OP_STACK_RESTORE) begin
            asel_d = SP_IDX;
            am_d = AM_POSTINC;
         end
         if (op_code_i == OP_STACK_SAVE) begin
            asel_d = SP_IDX;
            am_d = AM_PREDEC;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_q <= OP_XFER_REG;
         size_q <= SZ_B;
         am_q <= AM_IND;
         dsel_q <= 4'h0;
         ssel_q <= 4'h0;
         asel_q <= 3'h0;
         step_q <= 3'h0;
         immf_q <= 1'b0;
         imm_q <= 32'h0000_0000;
      end else begin
         op_q <= op_d;
         size_q <= size_d;
         am_q <= am_d;
         dsel_q <= dsel_d;
         ssel_q <= ssel_d;
         asel_q <= asel_d;
         step_q <= step_d;
         immf_q <= immf_d;
         imm_q <= imm_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // execution: one shared adder serves add, subtract and the step forms
   always_comb begin
      logic [31:0] a, b, r, v, x, t, ma, mb, n;
      logic [32:0] wide;
      logic [7:0] corr;
      logic cin, sub, cy, hc, ov, bad, dst_wr, upd_nz, upd_v, upd_c, nv, nc;
      int hb;
      ctad_size_t ws;
      a = extract(rfa, size_q, dsel_q);
      b = immf_q ? (imm_q & szmask(size_q)) : extract(rfb, size_q, ssel_q);
      r = 32'h0;
      v = 32'h0;
      t = extract(rfa, SZ_W, dsel_q);
      ma = 32'h0;
      mb = 32'h0;
      n = BYTES_L;
      corr = 8'h00;
      cin = 1'b0;
      cy = 1'b0;
      dst_wr = 1'b0;
      upd_nz = 1'b0;
      upd_v = 1'b0;
      upd_c = 1'b0;
      nv = 1'b0;
      nc = flags_q[FLAG_C];
      ws = size_q;
      state_d = state_q;
      flags_d = flags_q;
      result_d = result_q;
      done_d = 1'b0;
      ill_d = 1'b0;
      zchk_d = 1'b0;
      mreq_d = mreq_q;
      mwe_d = mwe_q;
      msize_d = msize_q;
      maddr_d = maddr_q;
      mwdata_d = mwdata_q;
      wr_en = 1'b0;
      wr_idx = dsel_q[2:0];
      wr_lane = LANE_L;
      wr_data = 32'h0;
      sub = op_q inside {OP_MINUS, OP_MINUS_B, OP_COUNT_DOWN, OP_MINUS_K};
      if (op_q inside {OP_PLUS_C, OP_MINUS_B}) begin
         cin = flags_q[FLAG_C];
      end
      if (op_q inside {OP_COUNT_UP, OP_COUNT_DOWN, OP_PLUS_K, OP_MINUS_K}) begin
         b = {29'h0, step_q};
      end
      if (sub) begin
         wide = {1'b0, a} - {1'b0, b} - {32'h0, cin};
      end else begin
         wide = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      end
      r = wide[31:0] & szmask(size_q);
      x = a ^ b ^ wide[31:0];
      hb = (size_q == SZ_B) ? HB_B : ((size_q == SZ_W) ? HB_W : HB_L);
      hc = x[hb];
      cy = (size_q == SZ_B) ? wide[8] : ((size_q == SZ_W) ? wide[16] : wide[32]);
      if (sub) begin
         ov = (msb(a, size_q) != msb(b, size_q)) && (msb(r, size_q) != msb(a, size_q));
      end else begin
         ov = (msb(a, size_q) == msb(b, size_q)) && (msb(r, size_q) != msb(a, size_q));
      end
      // size rejects; a size code of 3 is never legal
      unique case (op_q)
         OP_PERI_RD, OP_PERI_WR: bad = 1'b1;
         OP_MINUS: bad = immf_q && (size_q == SZ_B);
         OP_PLUS_C, OP_MINUS_B, OP_ADJ_ADD, OP_ADJ_SUB: bad = (size_q != SZ_B);
         OP_COUNT_UP, OP_COUNT_DOWN:
            bad = !((step_q == STEP_1) || ((step_q == STEP_2) && (size_q != SZ_B)));
         OP_PLUS_K, OP_MINUS_K:
            bad = (size_q != SZ_L) || !(step_q inside {STEP_1, STEP_2, STEP_4});
         OP_MUL_U, OP_MUL_S: bad = (size_q == SZ_L);
         OP_STACK_RESTORE, OP_STACK_SAVE: bad = (size_q == SZ_B);
         OP_XFER_REG, OP_XFER_IMM, OP_LOAD, OP_STORE, OP_PLUS: bad = 1'b0;
         default: bad = 1'b1;
      endcase
      if (!(size_q inside {SZ_B, SZ_W, SZ_L})) begin
         bad = 1'b1;
      end
      n = (size_q == SZ_B) ? BYTES_B : ((size_q == SZ_W) ? BYTES_W : BYTES_L);

      unique case (state_q)
         S_IDLE: begin
            if (acc) begin
               state_d = S_READ;
            end
         end
         S_READ: state_d = S_EXEC;
         S_EXEC: begin
            state_d = S_IDLE;
            if (bad) begin
               ill_d = 1'b1;
            end else if (is_mem(op_q)) begin
               // address register moves before the access; the stored value was read first
               state_d = S_MEM;
               mreq_d = 1'b1;
               mwe_d = op_q inside {OP_STORE, OP_STACK_SAVE};
               msize_d = size_q;
               maddr_d = (am_q == AM_PREDEC) ? rfa - n : rfa;
               mwdata_d = extract(rfb, size_q, ssel_q);
               if (am_q != AM_IND) begin
                  wr_en = 1'b1;
                  wr_idx = asel_q;
                  wr_lane = LANE_L;
                  wr_data = (am_q == AM_PREDEC) ? rfa - n : rfa + n;
               end
            end else begin
               done_d = 1'b1;
               dst_wr = 1'b1;
               unique case (op_q)
                  OP_XFER_REG, OP_XFER_IMM: begin
                     v = b;
                     upd_nz = 1'b1;
                     upd_v = 1'b1;
                  end
                  OP_PLUS, OP_MINUS, OP_PLUS_C, OP_MINUS_B: begin
                     v = r;
                     upd_nz = 1'b1;
                     upd_v = 1'b1;
                     upd_c = 1'b1;
                     nv = ov;
                     nc = cy;
                     flags_d[FLAG_H] = hc;
                  end
                  OP_COUNT_UP, OP_COUNT_DOWN: begin
                     v = r;
                     upd_nz = 1'b1;
                     upd_v = 1'b1;
                     nv = ov;
                  end
                  OP_PLUS_K, OP_MINUS_K: v = r;
                  OP_ADJ_ADD: begin
                     if (flags_q[FLAG_C] || (a[7:0] > BCD_MAX)) begin
                        corr = BCD_HI_FIX;
                        nc = 1'b1;
                     end
                     if (flags_q[FLAG_H] || (a[3:0] > NIB_MAX)) begin
                        corr = corr | BCD_LO_FIX;
                     end
                     v = {24'h0, a[7:0] + corr};
                     upd_nz = 1'b1;
                     upd_c = 1'b1;
                  end
                  OP_ADJ_SUB: begin
                     corr = (flags_q[FLAG_C] ? BCD_HI_FIX : 8'h00) |
                            (flags_q[FLAG_H] ? BCD_LO_FIX : 8'h00);
                     v = {24'h0, a[7:0] - corr};
                     upd_nz = 1'b1;
                     upd_c = 1'b1;
                  end
                  default: begin
                     // low half of a sign-extended product is the signed product
                     ws = (size_q == SZ_B) ? SZ_W : SZ_L;
                     if (op_q == OP_MUL_S) begin
                        ma = (size_q == SZ_B) ? {{24{t[7]}}, t[7:0]} : {{16{rfa[15]}}, rfa[15:0]};
                        mb = (size_q == SZ_B) ? {{24{b[7]}}, b[7:0]} : {{16{b[15]}}, b[15:0]};
                        upd_nz = 1'b1;
                     end else begin
                        ma = (size_q == SZ_B) ? {24'h0, t[7:0]} : {16'h0, rfa[15:0]};
                        mb = b;
                     end
                     v = ma * mb;
                  end
               endcase
            end
         end
         S_MEM: begin
            if (mem_ack_i) begin
               mreq_d = 1'b0;
               done_d = 1'b1;
               state_d = S_IDLE;
               if (mwe_q) begin
                  result_d = mwdata_q;
               end else begin
                  v = mem_rdata_i & szmask(size_q);
                  dst_wr = 1'b1;
                  upd_nz = 1'b1;
                  upd_v = 1'b1;
               end
            end
         end
         default: state_d = S_IDLE;
      endcase

      // destination write through the selected view
      if (dst_wr) begin
         v = v & szmask(ws);
         wr_en = 1'b1;
         wr_idx = dsel_q[2:0];
         wr_lane = lanes(ws, dsel_q);
         wr_data = spread(v, ws);
         result_d = v;
      end
      if (upd_nz) begin
         flags_d[FLAG_N] = msb(v, ws);
         flags_d[FLAG_Z] = (v == 32'h0);
         zchk_d = 1'b1;
      end
      if (upd_v) begin
         flags_d[FLAG_V] = nv;
      end
      if (upd_c) begin
         flags_d[FLAG_C] = nc;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= S_IDLE;
         flags_q <= FLAGS_RST;
         result_q <= 32'h0000_0000;
         done_q <= 1'b0;
         ill_q <= 1'b0;
         zchk_q <= 1'b0;
         mreq_q <= 1'b0;
         mwe_q <= 1'b0;
         msize_q <= SZ_B;
         maddr_q <= 32'h0000_0000;
         mwdata_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         flags_q <= flags_d;
         result_q <= result_d;
         done_q <= done_d;
         ill_q <= ill_d;
         zchk_q <= zchk_d;
         mreq_q <= mreq_d;
         mwe_q <= mwe_d;
         msize_q <= msize_d;
         maddr_q <= maddr_d;
         mwdata_q <= mwdata_d;
      end
   end

   assign done_o = done_q;
   assign illegal_o = ill_q;
   assign result_o = result_q;
   assign flags_o = flags_q;
   assign mem_req_o = mreq_q;
   assign mem_we_o = mwe_q;
   assign mem_size_o = msize_q;
   assign mem_addr_o = maddr_q;
   assign mem_wdata_o = mwdata_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_peri_refused: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && (op_code_i inside {OP_PERI_RD, OP_PERI_WR}) |-> ##3 illegal_o && !done_o)
      else $error("peripheral byte op not refused");
   chk_minus_imm_byte: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && op_code_i == OP_MINUS && use_imm_i && op_size_i == SZ_B |-> ##3 illegal_o)
      else $error("byte immediate minus accepted");
   chk_carry_byte_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && (op_code_i inside {OP_PLUS_C, OP_MINUS_B}) && op_size_i != SZ_B
      |-> ##3 illegal_o) else $error("carry op of wide size accepted");
   chk_count_byte_step: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && (op_code_i inside {OP_COUNT_UP, OP_COUNT_DOWN}) && op_size_i == SZ_B
      && step_i == STEP_2 |-> ##3 illegal_o) else $error("byte count by two accepted");
   chk_longk_size: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && (op_code_i inside {OP_PLUS_K, OP_MINUS_K}) && op_size_i != SZ_L
      |-> ##3 illegal_o) else $error("long constant op of short size accepted");
   chk_plus_done: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      acc && op_code_i == OP_PLUS |-> !done_o ##1 !done_o ##1 !done_o ##1 (done_o && !illegal_o))
      else $error("plus did not retire in three cycles");
   chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_o && zchk_q |-> flags_o[FLAG_Z] == (result_o == 32'h0))
      else $error("zero flag disagrees with result");
   chk_mem_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
      else $error("memory request dropped or changed before ack");
   chk_save_writes: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mem_req_o && op_q == OP_STACK_SAVE |-> mem_we_o) else $error("stack save not a write");
   chk_restore_reads: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mem_req_o && op_q == OP_STACK_RESTORE |-> !mem_we_o) else $error("stack restore wrote");
endmodule : ctad_datapath

// >>> test/ctad_datapath_tb.sv
// Purpose: self-checking bench for the transfer and arithmetic datapath
// Assumes: memory side answered by the bench with a one-cycle ack
// Notes: inputs move on the falling edge; one operation at a time
`timescale 1ns/1ps
module ctad_datapath_tb;
   import ctad_pkg::*;
   logic sys_clk_i, rst_b_i, op_valid_i, use_imm_i, mem_ack_i, ill;
   ctad_op_t op_code_i;
   ctad_size_t op_size_i;
   logic [3:0] dst_sel_i, src_sel_i;
   logic [2:0] step_i;
   logic [31:0] imm_i, mem_rdata_i, res, m_addr, m_wdata;
   logic [4:0] fl;
   logic m_we;
   ctad_size_t m_sz;
   logic [2:0] a_sel = 3'h0;
   ctad_am_t a_mode = AM_IND;
   int fail_count = 0;
   int n_tests = 0;
   ctad_datapath i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
      .op_ready_o(), .op_code_i(op_code_i), .op_size_i(op_size_i), .dst_sel_i(dst_sel_i),
      .src_sel_i(src_sel_i), .addr_sel_i(a_sel), .addr_mode_i(a_mode), .use_imm_i(use_imm_i),
      .imm_i(imm_i), .step_i(step_i), .done_o(), .illegal_o(), .result_o(), .flags_o(),
      .mem_req_o(), .mem_we_o(), .mem_size_o(), .mem_addr_o(), .mem_wdata_o(),
      .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
      end
   endtask : chk_v
   // one request, then serve memory until retirement; bounded so a hang shows
   task automatic run_op(input ctad_op_t op, input ctad_size_t sz, input logic [3:0] d,
      input logic [3:0] s, input logic ui, input logic [31:0] imm, input logic [2:0] st);
      int n;
      @(negedge sys_clk_i);
      op_valid_i = 1'b1;
      op_code_i = op;
      op_size_i = sz;
      dst_sel_i = d;
      src_sel_i = s;
      use_imm_i = ui;
      imm_i = imm;
      step_i = st;
      @(negedge sys_clk_i);
      op_valid_i = 1'b0;
      chk_v({31'h0, i_dut.op_ready_o}, 32'h0);
      for (n = 0; n < 40; n++) begin
         @(negedge sys_clk_i);
         mem_ack_i = 1'b0;
         if (i_dut.done_o === 1'b1 || i_dut.illegal_o === 1'b1) break;
         if (i_dut.mem_req_o === 1'b1) begin
            m_addr = i_dut.mem_addr_o;
            m_we = i_dut.mem_we_o;
            m_wdata = i_dut.mem_wdata_o;
            m_sz = i_dut.mem_size_o;
            mem_ack_i = 1'b1;
         end
      end
      if (n == 40) chk_v(32'h1, 32'h0);
      ill = i_dut.illegal_o; res = i_dut.result_o; fl = i_dut.flags_o;
   endtask : run_op
   ////////////////////////////////////////////////////////////////////////////
   ctad_op_t pe[2] = '{OP_PERI_RD, OP_PERI_WR};
   // byte write into a long keeps the other bytes
   task automatic t_move;
      run_op(OP_XFER_IMM, SZ_L, 4'h0, 4'h0, 1'b1, 32'h1234_5678, STEP_1);
      run_op(OP_XFER_IMM, SZ_B, 4'h8, 4'h0, 1'b1, 32'h0000_00ab, STEP_1);
      run_op(OP_XFER_REG, SZ_L, 4'h1, 4'h0, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'h1234_56ab);
      foreach (pe[i]) begin
         run_op(pe[i], SZ_B, 4'h8, 4'h0, 1'b0, 32'h0, STEP_1);
         chk_v({31'h0, ill}, 32'h1);
      end
   endtask : t_move
   // long add wraps to zero with carry, then carry folds into a byte add
   task automatic t_add;
      run_op(OP_PLUS, SZ_L, 4'h0, 4'h0, 1'b1, 32'hedcb_a955, STEP_1);
      chk_v({res[26:0], fl}, {27'h0, 5'h15});
      run_op(OP_MINUS, SZ_B, 4'h8, 4'h0, 1'b1, 32'h1, STEP_1);
      chk_v({31'h0, ill}, 32'h1);
      run_op(OP_PLUS_C, SZ_W, 4'h0, 4'h0, 1'b1, 32'h1, STEP_1);
      chk_v({31'h0, ill}, 32'h1);
      run_op(OP_PLUS_C, SZ_B, 4'h8, 4'h0, 1'b1, 32'h5, STEP_1);
      chk_v(res, 32'h6);
   endtask : t_add
   // step limits per size
   task automatic t_step;
      run_op(OP_COUNT_UP, SZ_B, 4'ha, 4'h0, 1'b0, 32'h0, STEP_2);
      chk_v({31'h0, ill}, 32'h1);
      run_op(OP_COUNT_UP, SZ_W, 4'h2, 4'h0, 1'b0, 32'h0, STEP_2);
      chk_v(res, 32'h2);
      run_op(OP_PLUS_K, SZ_L, 4'h2, 4'h0, 1'b0, 32'h0, STEP_4);
      chk_v(res, 32'h6);
      run_op(OP_MINUS_K, SZ_W, 4'h2, 4'h0, 1'b0, 32'h0, STEP_1);
      chk_v({31'h0, ill}, 32'h1);
      run_op(OP_COUNT_DOWN, SZ_B, 4'ha, 4'h0, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'h5);
   endtask : t_step
   // bcd 38 + 45 adjusts to 83; multiply both signednesses
   task automatic t_adj_mul;
      run_op(OP_XFER_IMM, SZ_B, 4'hb, 4'h0, 1'b1, 32'h38, STEP_1);
      run_op(OP_PLUS, SZ_B, 4'hb, 4'h0, 1'b1, 32'h45, STEP_1);
      run_op(OP_ADJ_ADD, SZ_B, 4'hb, 4'h0, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'h83);
      run_op(OP_XFER_IMM, SZ_B, 4'hd, 4'h0, 1'b1, 32'hff, STEP_1);
      for (int k = 0; k < 2; k++) begin
         run_op(OP_XFER_IMM, SZ_W, 4'h4, 4'h0, 1'b1, 32'hff, STEP_1);
         run_op(k ? OP_MUL_S : OP_MUL_U, SZ_B, 4'h4, 4'hd, 1'b0, 32'h0, STEP_1);
         chk_v(res, k ? 32'h1 : 32'hfe01);
      end
      run_op(OP_MUL_U, SZ_L, 4'h4, 4'h5, 1'b0, 32'h0, STEP_1);
      chk_v({31'h0, ill}, 32'h1);
   endtask : t_adj_mul
   // save predecrements, restore postincrements the stack pointer
   task automatic t_stack;
      run_op(OP_XFER_IMM, SZ_L, 4'h7, 4'h0, 1'b1, 32'h1000, STEP_1);
      run_op(OP_STACK_SAVE, SZ_W, 4'h2, 4'h2, 1'b0, 32'h0, STEP_1);
      chk_v({m_addr[30:0], m_we}, {31'hffe, 1'b1});
      chk_v(m_wdata & MASK_W, 32'h5);
      chk_v({30'h0, m_sz}, {30'h0, SZ_W});
      mem_rdata_i = 32'hcafe_f00d;
      run_op(OP_STACK_RESTORE, SZ_L, 4'h1, 4'h1, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'hcafe_f00d);
      chk_v(m_addr, 32'hffe);
      run_op(OP_XFER_REG, SZ_L, 4'h6, 4'h7, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'h1002);
      run_op(OP_STACK_SAVE, SZ_B, 4'h8, 4'h8, 1'b0, 32'h0, STEP_1);
      chk_v({31'h0, ill}, 32'h1);
      // plain load through r6, then a byte store that bumps r6
      a_sel = 3'h6;
      run_op(OP_LOAD, SZ_W, 4'h3, 4'h0, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'hf00d);
      chk_v({m_addr[30:0], m_we}, {31'h1002, 1'b0});
      a_mode = AM_POSTINC;
      run_op(OP_STORE, SZ_B, 4'h0, 4'h9, 1'b0, 32'h0, STEP_1);
      chk_v(m_wdata & MASK_B, 32'hd);
      run_op(OP_XFER_REG, SZ_L, 4'h0, 4'h6, 1'b0, 32'h0, STEP_1);
      chk_v(res, 32'h1003);
   endtask : t_stack
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // clock at 100 MHz
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // watchdog at 20000 cycles; the whole run is well under that
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end
   // reset for 16 cycles, then the scenarios
   initial begin
      rst_b_i = 1'b0;
      op_valid_i = 1'b0;
      op_code_i = OP_XFER_REG;
      op_size_i = SZ_B;
      dst_sel_i = 4'h0;
      src_sel_i = 4'h0;
      use_imm_i = 1'b0;
      imm_i = 32'h0;
      step_i = STEP_1;
      mem_ack_i = 1'b0;
      mem_rdata_i = 32'h0;
      repeat (16) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      t_move();
      t_add();
      t_step();
      t_adj_mul();
      t_stack();
      print_verdict();
   end
endmodule : ctad_datapath_tb
